// ---- core/uart_flow_control.sv ----
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "uart_flow_regs.svh"
module uart_flow_control
(
  input logic aclk,
  input logic aresetn,
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input uart_flow_pkg::char_s [1:0] rx_in,
  output uart_flow_pkg::char_s [1:0] rx_store,
  input uart_flow_pkg::byte_t [1:0] rx_level,
  input uart_flow_pkg::byte_t [1:0] tx_level,
  input logic [1:0] send_pause,
  input logic [1:0] send_resume,
  output uart_flow_pkg::char_s [1:0] fc_out,
  input logic [1:0] fc_ready,
  output logic [1:0] tx_allowed,
  input uart_flow_pkg::modem_in_s [1:0] modem_in,
  output uart_flow_pkg::pins_s [1:0] pins,
  output logic [1:0] irq
);
  import uart_flow_pkg::*;

  // per-channel register copies
  byte_t [1:0] scratch_q, feature_q, enh_q, pause1_q, pause2_q, resume1_q, resume2_q;
  byte_t [1:0] int_en_q, fifo_ctl_q, modem_ctl_q, mode_sel_q, trig_rx_q, trig_tx_q;
  logic [1:0][1:0] int_stat_q;
  logic [1:0][3:0] modem_chg_q;
  modem_in_s [1:0] modem_prev_q;
  logic [1:0] modem_ok_q, alt_q, paused_q, prev_ok_q, rts_hold_q, irq_q, tx_allowed_q;
  byte_t [1:0] prev_q, fc_next_q;
  char_s [1:0] rx_store_q, fc_q;
  fc_state_e [1:0] fc_state_q;
  pins_s [1:0] pins_q;
  logic [1:0] pause_hit, resume_hit, special_hit, keep_char;
  logic [1:0][8:0] rts_up, rts_lo;

  // bus slave state
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q, w_lane_q, wr_fire, wr_en, rd_fire;
  logic [7:0] aw_addr_q;
  byte_t w_data_q, rd_val;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic wr_ch, rd_ch;
  logic [3:0] wr_idx, rd_idx;

  function automatic logic addr_ok(logic [7:0] a);
    return !a[`ADDR_TOP_BIT] && (a[`IDX_MSB:`IDX_LSB] <= `IDX_LAST);
  endfunction

  // protected bits keep their value unless enhanced writes are enabled
  function automatic byte_t guard(byte_t old, byte_t nv, byte_t mask, logic en);
    return en ? nv : ((old & mask) | (nv & ~mask));
  endfunction

  function automatic byte_t hyst(logic [1:0] ext, logic [1:0] sel);
    case ({ext, sel})
      4'h0: return 8'h00;
      4'h1: return 8'h04;
      4'h2: return 8'h06;
      4'h3: return 8'h08;
      4'h4: return 8'h08;
      4'h5: return 8'h10;
      4'h6: return 8'h18;
      4'h7: return 8'h20;
      4'h8: return 8'h28;
      4'h9: return 8'h2C;
      4'hA: return 8'h30;
      4'hB: return 8'h34;
      4'hC: return 8'h0C;
      4'hD: return 8'h14;
      4'hE: return 8'h1C;
      default: return 8'h24;
    endcase
  endfunction

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  // upper byte lanes carry nothing, so only lane 0 commits
  assign wr_en = wr_fire && addr_ok(aw_addr_q) && w_lane_q;
  assign wr_ch = aw_addr_q[`CH_BIT];
  assign wr_idx = aw_addr_q[`IDX_MSB:`IDX_LSB];
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  assign rd_ch = s_axi_araddr[`CH_BIT];
  assign rd_idx = s_axi_araddr[`IDX_MSB:`IDX_LSB];
  assign rx_store = rx_store_q;
  assign fc_out = fc_q;
  assign pins = pins_q;
  assign irq = irq_q;
  assign tx_allowed = tx_allowed_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      aw_addr_q <= `RST_ZERO;
      w_data_q <= `RST_ZERO;
      w_lane_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= addr_ok(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, addr_ok(s_axi_araddr) ? rd_val : `RST_ZERO};
      rresp_q <= addr_ok(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  always_comb
  begin
    byte_t cnt;
    cnt = rx_level[rd_ch];
    if (mode_sel_q[rd_ch][1:0] == `CNT_TX || (mode_sel_q[rd_ch][1:0] == `CNT_ALT && alt_q[rd_ch]))
      cnt = tx_level[rd_ch];
    rd_val = `RST_ZERO;
    case (rd_idx)
      `IDX_SCRATCH: rd_val = feature_q[rd_ch][`SWAP_BIT] ? cnt : scratch_q[rd_ch];
      `IDX_FEATURE: rd_val = feature_q[rd_ch];
      `IDX_ENH: rd_val = enh_q[rd_ch];
      `IDX_PAUSE1: rd_val = pause1_q[rd_ch];
      `IDX_PAUSE2: rd_val = pause2_q[rd_ch];
      `IDX_RESUME1: rd_val = resume1_q[rd_ch];
      `IDX_RESUME2: rd_val = resume2_q[rd_ch];
      `IDX_INT_EN: rd_val = int_en_q[rd_ch];
      `IDX_INT_STAT: rd_val = {2'b00, int_stat_q[rd_ch], 3'b000, !irq_q[rd_ch]} | `RST_ZERO;
      `IDX_FIFO_CTL: rd_val = fifo_ctl_q[rd_ch];
      `IDX_MODEM_CTL: rd_val = modem_ctl_q[rd_ch];
      // no receiver in this block: line status reports an idle transmitter
      `IDX_LINE_STAT: rd_val = `LSR_IDLE;
      `IDX_MODEM_STAT: rd_val = {~modem_in[rd_ch], modem_chg_q[rd_ch]};
      `IDX_TRIGGER: rd_val = feature_q[rd_ch][`TRGSEL_BIT] ? tx_level[rd_ch]
        : rx_level[rd_ch];
      default: rd_val = `RST_ZERO;
    endcase
  end

  // received character classification
  always_comb
  begin
    logic [1:0] rxm, txm;
    logic one1, one2, seq;
    byte_t d;
    rxm = `FC_NONE;
    txm = `FC_NONE;
    one1 = 1'b0;
    one2 = 1'b0;
    seq = 1'b0;
    d = `RST_ZERO;
    for (int c = 0; c < 2; c++)
    begin
      rxm = enh_q[c][1:0];
      txm = enh_q[c][3:2];
      d = rx_in[c].data;
      one1 = rxm == `FC_FIRST || (rxm == `FC_BOTH && txm != `FC_NONE && txm != `FC_BOTH);
      one2 = rxm == `FC_SECOND || (rxm == `FC_BOTH && txm != `FC_NONE && txm != `FC_BOTH);
      seq = rxm == `FC_BOTH && (txm == `FC_NONE || txm == `FC_BOTH);
      pause_hit[c] = rx_in[c].valid && ((one1 && d == pause1_q[c]) || (one2 && d == pause2_q[c])
        || (seq && prev_ok_q[c] && prev_q[c] == pause1_q[c] && d == pause2_q[c]));
      resume_hit[c] = rx_in[c].valid && ((one1 && d == resume1_q[c]) || (one2 && d == resume2_q[c])
        || (seq && prev_ok_q[c] && prev_q[c] == resume1_q[c] && d == resume2_q[c]));
      special_hit[c] = rx_in[c].valid && enh_q[c][`SPECIAL_BIT] && d == pause2_q[c];
      keep_char[c] = special_hit[c] ? (rxm != `FC_SECOND)
        : !(pause_hit[c] || resume_hit[c]);
      rts_up[c] = {1'b0, trig_rx_q[c]} + {1'b0, hyst(mode_sel_q[c][5:4], feature_q[c][1:0])};
      rts_lo[c] = {1'b0, trig_rx_q[c]} - {1'b0, hyst(mode_sel_q[c][5:4], feature_q[c][1:0])};
      if (trig_rx_q[c] < hyst(mode_sel_q[c][5:4], feature_q[c][1:0]))
        rts_lo[c] = 9'h000;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scratch_q <= {2{`RST_SCRATCH}};
      mode_sel_q <= {2{`RST_MODE_SEL}};
      feature_q <= '0;
      enh_q <= '0;
      pause1_q <= '0;
      pause2_q <= '0;
      resume1_q <= '0;
      resume2_q <= '0;
      int_en_q <= '0;
      int_stat_q <= '0;
      fifo_ctl_q <= '0;
      modem_ctl_q <= '0;
      trig_rx_q <= '0;
      trig_tx_q <= '0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (wr_en && wr_ch == 1'(c))
        begin
          case (wr_idx)
            `IDX_SCRATCH:
              if (feature_q[c][`SWAP_BIT])
                mode_sel_q[c] <= w_data_q;
              else
                scratch_q[c] <= w_data_q;
            `IDX_FEATURE: feature_q[c] <= w_data_q;
            `IDX_ENH: enh_q[c] <= w_data_q;
            `IDX_PAUSE1: pause1_q[c] <= w_data_q;
            `IDX_PAUSE2: pause2_q[c] <= w_data_q;
            `IDX_RESUME1: resume1_q[c] <= w_data_q;
            `IDX_RESUME2: resume2_q[c] <= w_data_q;
            `IDX_INT_EN: int_en_q[c] <= guard(int_en_q[c], w_data_q, `MASK_IEN,
              enh_q[c][`ENH_BIT]);
            `IDX_INT_STAT:
              if (enh_q[c][`ENH_BIT])
                int_stat_q[c] <= w_data_q[`ISTAT_LSB +: 2];
            `IDX_FIFO_CTL: fifo_ctl_q[c] <= guard(fifo_ctl_q[c], w_data_q, `MASK_FCTL,
              enh_q[c][`ENH_BIT]);
            `IDX_MODEM_CTL: modem_ctl_q[c] <= guard(modem_ctl_q[c], w_data_q, `MASK_MCTL,
              enh_q[c][`ENH_BIT]);
            `IDX_TRIGGER:
              if (feature_q[c][`TRGSEL_BIT])
                trig_tx_q[c] <= w_data_q;
              else
                trig_rx_q[c] <= w_data_q;
            default: ;
          endcase
        end
        if (rd_fire && rd_ch == 1'(c) && rd_idx == `IDX_INT_STAT)
          int_stat_q[c] <= 2'b00;
        // set after clear so a same-cycle event survives
        if (special_hit[c])
          int_stat_q[c][0] <= 1'b1;
        if (pause_hit[c])
          int_stat_q[c][1] <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      alt_q <= '0;
    else
      for (int c = 0; c < 2; c++)
        if (wr_en && wr_ch == 1'(c) && wr_idx == `IDX_SCRATCH && feature_q[c][`SWAP_BIT])
          alt_q[c] <= 1'b0;
        else if (rd_fire && rd_ch == 1'(c) && rd_idx == `IDX_SCRATCH
          && feature_q[c][`SWAP_BIT] && mode_sel_q[c][1:0] == `CNT_ALT)
          alt_q[c] <= !alt_q[c];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      modem_prev_q <= '0;
      modem_ok_q <= '0;
      modem_chg_q <= '0;
    end
    else
      for (int c = 0; c < 2; c++)
      begin
        modem_prev_q[c] <= modem_in[c];
        modem_ok_q[c] <= 1'b1;
        modem_chg_q[c] <= ((rd_fire && rd_ch == 1'(c) && rd_idx == `IDX_MODEM_STAT) ?
          4'h0 : modem_chg_q[c]) | (modem_ok_q[c] ? 4'(modem_prev_q[c] ^ modem_in[c]) : 4'h0);
      end
  end

  // first character of a sequence is already passed on before the second arrives
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_store_q <= '0;
      prev_q <= '0;
      prev_ok_q <= '0;
      paused_q <= '0;
    end
    else
      for (int c = 0; c < 2; c++)
      begin
        rx_store_q[c].valid <= rx_in[c].valid && keep_char[c];
        rx_store_q[c].data <= rx_in[c].data;
        if (rx_in[c].valid)
        begin
          prev_q[c] <= rx_in[c].data;
          prev_ok_q[c] <= 1'b1;
        end
        if (enh_q[c][1:0] == `FC_NONE)
          paused_q[c] <= 1'b0;
        else if (pause_hit[c])
          paused_q[c] <= 1'b1;
        else if (resume_hit[c])
          paused_q[c] <= 1'b0;
      end
  end

  // requests that arrive while a pair is still going out are dropped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fc_state_q <= '{FC_IDLE, FC_IDLE};
      fc_q <= '0;
      fc_next_q <= '0;
    end
    else
      for (int c = 0; c < 2; c++)
        case (fc_state_q[c])
          FC_IDLE:
            if ((send_pause[c] || send_resume[c]) && enh_q[c][3:2] != `FC_NONE)
            begin
              fc_q[c].valid <= 1'b1;
              if (enh_q[c][3:2] == `FC_SECOND)
                fc_q[c].data <= send_pause[c] ? pause2_q[c] : resume2_q[c];
              else
                fc_q[c].data <= send_pause[c] ? pause1_q[c] : resume1_q[c];
              fc_next_q[c] <= send_pause[c] ? pause2_q[c] : resume2_q[c];
              fc_state_q[c] <= (enh_q[c][3:2] == `FC_BOTH) ? FC_ONE : FC_TWO;
            end
          FC_ONE:
            if (fc_ready[c])
            begin
              fc_q[c].data <= fc_next_q[c];
              fc_state_q[c] <= FC_TWO;
            end
          FC_TWO:
            if (fc_ready[c])
            begin
              fc_q[c].valid <= 1'b0;
              fc_state_q[c] <= FC_IDLE;
            end
          default:
          begin
            fc_q[c].valid <= 1'b0;
            fc_state_q[c] <= FC_IDLE;
          end
        endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rts_hold_q <= '0;
    else
      for (int c = 0; c < 2; c++)
        if (!enh_q[c][`ARTS_BIT])
          rts_hold_q[c] <= 1'b0;
        else if ({1'b0, rx_level[c]} >= rts_up[c])
          rts_hold_q[c] <= 1'b1;
        else if ({1'b0, rx_level[c]} < rts_lo[c])
          rts_hold_q[c] <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pins_q <= {2{`RST_PINS}};
      irq_q <= '0;
      tx_allowed_q <= '0;
    end
    else
      for (int c = 0; c < 2; c++)
      begin
        pins_q[c].tx <= 1'b1;
        pins_q[c].rts_n <= (enh_q[c][`ARTS_BIT] && modem_ctl_q[c][`MCR_RTS_BIT]) ?
          rts_hold_q[c] : !modem_ctl_q[c][`MCR_RTS_BIT];
        pins_q[c].dtr_n <= !modem_ctl_q[c][`MCR_DTR_BIT];
        pins_q[c].user_output_one_n <= !modem_ctl_q[c][`MCR_OP1_BIT];
        pins_q[c].multi_function_n <= !modem_ctl_q[c][`MCR_MF_BIT];
        pins_q[c].transmit_ready_n <= tx_level[c][`TXFULL_BIT];
        irq_q[c] <= (int_en_q[c][`IEN_SPECIAL_BIT] && (|int_stat_q[c]))
          || (int_en_q[c][`IEN_RXTRIG_BIT] && rx_level[c] >= trig_rx_q[c]);
        tx_allowed_q[c] <= !(enh_q[c][`ACTS_BIT] && modem_in[c].cts_n) && !paused_q[c];
      end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_cts_stop;
    enh_q[0][`ACTS_BIT] && modem_in[0].cts_n |=> !tx_allowed[0];
  endproperty
  a_cts_stop: assert property (p_cts_stop) else $error("cts high did not stop tx");

  property p_rts_upper;
    enh_q[0][`ARTS_BIT] && {1'b0, rx_level[0]} >= rts_up[0] |=> rts_hold_q[0];
  endproperty
  a_rts_upper: assert property (p_rts_upper) else $error("rts not raised at upper");

  property p_rts_plain;
    !enh_q[0][`ARTS_BIT] |=> pins[0].rts_n == !$past(modem_ctl_q[0][`MCR_RTS_BIT]);
  endproperty
  a_rts_plain: assert property (p_rts_plain) else $error("rts not plain output");

  property p_protect;
    wr_en && !wr_ch && wr_idx == `IDX_INT_EN && !enh_q[0][`ENH_BIT]
      |=> int_en_q[0][7:4] == $past(int_en_q[0][7:4]);
  endproperty
  a_protect: assert property (p_protect) else $error("protected bits changed");

  property p_swap_write;
    wr_en && !wr_ch && wr_idx == `IDX_SCRATCH && feature_q[0][`SWAP_BIT]
      |=> mode_sel_q[0] == $past(w_data_q) && $stable(scratch_q[0]);
  endproperty
  a_swap_write: assert property (p_swap_write) else $error("swap write misrouted");

  property p_plain_write;
    wr_en && !wr_ch && wr_idx == `IDX_SCRATCH && !feature_q[0][`SWAP_BIT]
      |=> scratch_q[0] == $past(w_data_q) && $stable(mode_sel_q[0]);
  endproperty
  a_plain_write: assert property (p_plain_write) else $error("scratch write lost");

  property p_special_drop;
    rx_in[0].valid && enh_q[0][`SPECIAL_BIT] && enh_q[0][1:0] == `FC_SECOND
      && rx_in[0].data == pause2_q[0]
      |=> !rx_store[0].valid && paused_q[0] && int_stat_q[0] == 2'b11;
  endproperty
  a_special_drop: assert property (p_special_drop) else $error("second pause stored");

  property p_special_keep;
    rx_in[0].valid && enh_q[0][`SPECIAL_BIT] && enh_q[0][1:0] != `FC_SECOND
      && rx_in[0].data == pause2_q[0] |=> rx_store[0].valid && int_stat_q[0][0];
  endproperty
  a_special_keep: assert property (p_special_keep) else $error("special char not kept");

  property p_pair_second;
    fc_state_q[0] == FC_ONE && fc_ready[0]
      |=> fc_out[0].valid && fc_out[0].data == $past(fc_next_q[0]);
  endproperty
  a_pair_second: assert property (p_pair_second) else $error("pair second char wrong");

endmodule

// ---- core/uart_flow_pkg.sv ----
package uart_flow_pkg;
  typedef logic [7:0] byte_t;
  typedef struct packed {
    logic valid;
    byte_t data;
  } char_s;
  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } modem_in_s;
  typedef struct packed {
    logic tx;
    logic rts_n;
    logic dtr_n;
    logic user_output_one_n;
    logic multi_function_n;
    logic transmit_ready_n;
  } pins_s;
  typedef enum logic [2:0] {
    FC_IDLE = 3'b001,
    FC_ONE = 3'b010,
    FC_TWO = 3'b100
  } fc_state_e;
endpackage

// ---- core/uart_flow_regs.svh ----
`ifndef UART_FLOW_REGS_SVH
`define UART_FLOW_REGS_SVH
// How it works
// - with swap bit clear the scratchpad is plain read/write storage.
// - with swap bit set, scratchpad reads give fifo count, writes load mode select.
// - trigger select bit steers trigger and count registers: 0 receive, 1 transmit.
// - transmit field: 00 none, 10 first pair, 01 second pair, 11 both.
// - receive field: 00 no compare, 10 first characters, 01 second characters.
// - receive 11 matches either single, or the two-character sequence per transmit field.
// - dual modes treat first and second characters as one consecutive pair.
// - enhanced-enable gates writes to protected interrupt, status, fifo, modem bits.
// - reset clears all protected enhanced bits.
// - special detect compares received characters with second pause; match stored, flagged.
// - receive-second mode: matching second pause not stored, raises pause and special.
// - auto rts: interrupt at trigger, rts high at or above upper, low below lower.
// - auto rts needs software rts asserted; otherwise rts is a plain output.
// - auto cts: transmission stops while cts is high.
// - four read/write pause and resume character registers.
// - reset clears modem change bits; upper bits show inverted modem inputs.
// - reset values of status, mode select, scratchpad and pins as listed.
// - mode select writable only under swap; low bits pick count reporting.
`define IDX_SCRATCH 4'h0
`define IDX_FEATURE 4'h1
`define IDX_ENH 4'h2
`define IDX_PAUSE1 4'h3
`define IDX_PAUSE2 4'h4
`define IDX_RESUME1 4'h5
`define IDX_RESUME2 4'h6
`define IDX_INT_EN 4'h7
`define IDX_INT_STAT 4'h8
`define IDX_FIFO_CTL 4'h9
`define IDX_MODEM_CTL 4'hA
`define IDX_LINE_STAT 4'hB
`define IDX_MODEM_STAT 4'hC
`define IDX_TRIGGER 4'hD
`define IDX_LAST 4'hD
`define ADDR_TOP_BIT 7
`define CH_BIT 6
`define IDX_MSB 5
`define IDX_LSB 2
`define RST_SCRATCH 8'hFF
`define RST_MODE_SEL 8'h80
`define RST_ZERO 8'h00
`define RST_PINS 6'h3E
`define ISR_IDLE 8'h01
`define LSR_IDLE 8'h60
`define SWAP_BIT 6
`define TRGSEL_BIT 7
`define ENH_BIT 4
`define SPECIAL_BIT 5
`define ARTS_BIT 6
`define ACTS_BIT 7
`define IEN_RXTRIG_BIT 0
`define IEN_SPECIAL_BIT 5
`define ISTAT_LSB 4
`define MCR_DTR_BIT 0
`define MCR_RTS_BIT 1
`define MCR_OP1_BIT 2
`define MCR_MF_BIT 3
`define TXFULL_BIT 7
`define MASK_IEN 8'hF0
`define MASK_FCTL 8'h30
`define MASK_MCTL 8'hE0
`define FC_NONE 2'b00
`define FC_FIRST 2'b10
`define FC_SECOND 2'b01
`define FC_BOTH 2'b11
`define CNT_TX 2'b01
`define CNT_ALT 2'b11
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ---- test/uart_flow_control_test.sv ----
`timescale 1ns/1ps
`include "uart_flow_regs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module uart_flow_control_test;
  import uart_flow_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, p_rdy, slow = 0, clr = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp, rr, br, send_pause = 0, send_resume = 0, tx_allowed, irq;
  char_s [1:0] rx_in = 0, rx_store, fc_out;
  byte_t [1:0] rx_level = 16'h0011, tx_level = 16'h0022;
  modem_in_s [1:0] modem_in = 8'hAF;
  pins_s [1:0] pins;
  byte_t got0, got1, rd, idx, m;
  byte_t fcv[4] = '{8'h13, 8'h93, 8'h11, 8'h91};
  byte_t ren[10] = '{8'h20, 8'h21, 8'h21, 8'h02, 8'h02, 8'h02, 8'h0B, 8'h0B, 8'h03, 8'h03};
  byte_t rch[10] = '{8'h93, 8'h93, 8'h91, 8'h13, 8'h41, 8'h11, 8'h93, 8'h11, 8'h13, 8'h93};
  byte_t risr[10] = '{8'h10, 8'h30, 8'h01, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h20, 8'hFF, 8'h20};
  logic rst[10] = '{1, 0, 0, 0, 1, 0, 0, 0, 1, 0};
  logic ral[10] = '{1, 0, 1, 0, 0, 1, 0, 1, 1, 0};
  int n_got, fail_count = 0, n_tests = 0;
  always #12.5 aclk = ~aclk;
  uart_flow_partner far_end (.aclk(aclk), .clr(clr), .slow(slow), .fc_out(fc_out[0]),
    .fc_ready(p_rdy), .got0(got0), .got1(got1), .n_got(n_got));
  uart_flow_control uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_in(rx_in),
    .rx_store(rx_store), .rx_level(rx_level), .tx_level(tx_level), .send_pause(send_pause),
    .send_resume(send_resume), .fc_out(fc_out), .fc_ready({1'b1, p_rdy}),
    .tx_allowed(tx_allowed), .modem_in(modem_in), .pins(pins), .irq(irq));
  // handshakes sampled mid-cycle, where comb readies are settled, released at the edge
  task automatic wr(input logic ch, input logic [3:0] i, input byte_t d);
    logic a, w, b;
    @(posedge aclk);
    awaddr <= {1'b0, ch, i, 2'b00};
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      br = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    while (!b);
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic ch, input logic [3:0] i);
    logic a, r;
    @(posedge aclk);
    araddr <= {1'b0, ch, i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      a = arvalid && arready;
      r = rvalid;
      rd = rdata[7:0];
      rr = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
    end
    while (!r);
    rready <= 1'b0;
  endtask
  task automatic rc(input logic ch, input logic [3:0] i, input byte_t e);
    rdr(ch, i);
    `CHK(rd, e)
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    report_and_stop;
  end
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK(pins, {`RST_PINS, `RST_PINS})
    `CHK(irq, 2'b00)
    for (int c = 0; c < 2; c++)
      for (int i = 0; i <= `IDX_MODEM_STAT; i++)
        rc(c, i, i == 0 ? 8'hFF : i == 8 ? 8'h01 : i == 11 ? 8'h60 :
          i == 12 ? {~modem_in[c], 4'h0} : 8'h00);
    rdr(0, 4'hE);
    `CHK({rr, rd}, {`RESP_SLVERR, 8'h00})
    wr(0, 4'hE, 8'h77);
    `CHK(br, `RESP_SLVERR)
    wr(0, `IDX_SCRATCH, 8'h5A);
    `CHK(br, `RESP_OKAY)
    rc(0, `IDX_SCRATCH, 8'h5A);
    wr(0, `IDX_FEATURE, 8'h40);
    rc(0, `IDX_SCRATCH, 8'h11);
    wr(0, `IDX_SCRATCH, 8'h01);
    rc(0, `IDX_SCRATCH, 8'h22);
    wr(0, `IDX_SCRATCH, 8'h03);
    for (int i = 0; i < 3; i++)
      rc(0, `IDX_SCRATCH, i == 1 ? 8'h22 : 8'h11);
    wr(0, `IDX_FEATURE, 8'h00);
    rc(0, `IDX_SCRATCH, 8'h5A);
    rc(0, `IDX_TRIGGER, 8'h11);
    wr(0, `IDX_FEATURE, 8'h80);
    rc(0, `IDX_TRIGGER, 8'h22);
    for (int j = 0; j < 3; j++)
    begin
      idx = j == 0 ? `IDX_INT_EN : j == 1 ? `IDX_FIFO_CTL : `IDX_MODEM_CTL;
      m = j == 0 ? `MASK_IEN : j == 1 ? `MASK_FCTL : `MASK_MCTL;
      wr(0, idx, 8'hFF);
      rc(0, idx, ~m);
      wr(0, `IDX_ENH, 8'h10);
      wr(0, idx, m);
      rc(0, idx, m);
      wr(0, `IDX_ENH, 8'h00);
      wr(0, idx, 8'h00);
      rc(0, idx, m);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(0, `IDX_PAUSE1 + i, fcv[i]);
      rc(0, `IDX_PAUSE1 + i, fcv[i]);
      rc(1, `IDX_PAUSE1 + i, 8'h00);
    end
    for (int k = 0; k < 5; k++)
    begin
      m = k == 0 ? 8'h08 : k == 1 ? 8'h04 : k == 3 ? 8'h00 : 8'h0C;
      wr(0, `IDX_ENH, 8'h00);
      wr(0, `IDX_ENH, m);
      clr <= 1'b1;
      slow <= (k == 2);
      @(posedge aclk) clr <= 1'b0;
      send_pause[0] <= (k != 4);
      send_resume[0] <= (k == 4);
      @(posedge aclk) {send_pause[0], send_resume[0]} <= 2'b00;
      settle(12);
      `CHK(n_got, k == 2 || k == 4 ? 2 : k == 3 ? 0 : 1)
      if (k != 3) `CHK(got0, k == 1 ? fcv[1] : k == 4 ? fcv[2] : fcv[0])
      if (k == 2 || k == 4) `CHK(got1, k == 2 ? fcv[1] : fcv[3])
    end
    // enhanced bit left low, so the latched interrupt enable 0xF0 keeps irq live
    for (int i = 0; i < 10; i++)
    begin
      if (i == 0 || ren[i] != ren[i - 1])
      begin
        wr(0, `IDX_ENH, 8'h00);
        wr(0, `IDX_ENH, ren[i]);
      end
      @(posedge aclk) rx_in[0] <= {1'b1, rch[i]};
      @(posedge aclk) rx_in[0] <= '0;
      @(negedge aclk);
      `CHK(rx_store[0].valid, rst[i])
      if (rst[i]) `CHK(rx_store[0].data, rch[i])
      settle(3);
      `CHK(tx_allowed[0], ral[i])
      if (risr[i] != 8'hFF) rc(0, `IDX_INT_STAT, risr[i]);
    end
    wr(0, `IDX_ENH, 8'h00);
    wr(0, `IDX_MODEM_CTL, 8'h02);
    settle(4);
    `CHK(pins[0].rts_n, 1'b0)
    wr(0, `IDX_FEATURE, 8'h01);
    wr(0, `IDX_TRIGGER, 8'h10);
    wr(0, `IDX_INT_EN, 8'h01);
    wr(0, `IDX_ENH, 8'h40);
    for (int i = 0; i < 4; i++)
    begin
      rx_level[0] <= i == 0 ? 8'h13 : i == 1 ? 8'h14 : i == 2 ? 8'h0C : 8'h0B;
      settle(4);
      `CHK(pins[0].rts_n, i == 1 || i == 2)
      `CHK(irq[0], i < 2)
    end
    wr(1, `IDX_ENH, 8'h80);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge aclk) modem_in[1].cts_n <= (i == 1);
      settle(4);
      `CHK(tx_allowed[1], i != 1)
    end
    report_and_stop;
  end
endmodule

// ---- test/uart_flow_partner.sv ----
`timescale 1ns/1ps
module uart_flow_partner
  import uart_flow_pkg::*;
(
  input wire logic aclk,
  input wire logic clr,
  input wire logic slow,
  input uart_flow_pkg::char_s fc_out,
  output logic fc_ready,
  output uart_flow_pkg::byte_t got0,
  output uart_flow_pkg::byte_t got1,
  output int n_got
);
  // slow mode stalls every other cycle, like a busy remote end
  always_ff @(posedge aclk)
  begin
    fc_ready <= slow ? ~fc_ready : 1'b1;
    if (clr)
      n_got <= 0;
    else if (fc_out.valid && fc_ready)
    begin
      if (n_got == 0)
        got0 <= fc_out.data;
      else
        got1 <= fc_out.data;
      n_got <= n_got + 1;
    end
  end
endmodule
